//--- hdl/bcs_counter_status.sv
// Four-decade BCD up/down counter with wrap, compare-match and zero outputs
module bcs_counter_status #(
  parameter bit COMMON_CATHODE = 1'b0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic count_in,
  input wire logic up_dn,
  input wire logic counter_preset_ctl,
  input wire logic [15:0] compare_raw,
  output logic wrap_pulse,
  output logic match_b,
  output logic null_b,
  output bcs_pkg::bcs_count_t count_q
);
  import bcs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and input synchronisers
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [2:0] cnt_sync_q;
  logic [1:0] dir_sync_q;
  logic [1:0] pre_sync_q;
  logic [15:0] cmp_s1_q;
  logic [15:0] cmp_q;
  logic [2:0] pin_rst_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_sync_q <= 3'h0;
      dir_sync_q <= 2'h0;
      pre_sync_q <= 2'h0;
      cmp_s1_q <= 16'h0000;
      cmp_q <= 16'h0000;
    end else begin
      cnt_sync_q <= {cnt_sync_q[1:0], count_in};
      dir_sync_q <= {dir_sync_q[0], up_dn};
      pre_sync_q <= {pre_sync_q[0], counter_preset_ctl};
      cmp_s1_q <= compare_raw;
      cmp_q <= COMMON_CATHODE ? ~cmp_s1_q : cmp_s1_q;
    end
  end

  // Raw reset level seen in the clock domain; third stage only feeds the fall detector
  always_ff @(posedge clk) begin
    pin_rst_q <= {pin_rst_q[1:0], rst_b};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter
  logic count_rise;
  logic [BCS_DIGITS:0] chain;
  logic [BCS_DIGITS-1:0] roll;
  logic [3:0] digit [BCS_DIGITS];
  logic inhibit;

  assign inhibit = pre_sync_q[1];
  assign count_rise = cnt_sync_q[1] && !cnt_sync_q[2] && !inhibit;
  assign chain[0] = count_rise;

  genvar gi;
  generate
    for (gi = 0; gi < BCS_DIGITS; gi++) begin : g_dec
      bcs_decade u_dec (
        .clk(clk),
        .rst_b(rst_n),
        .step(chain[gi]),
        .up(dir_sync_q[1]),
        .clear(1'b0),
        .digit_q(digit[gi]),
        .roll(roll[gi])
      );
      assign chain[gi+1] = roll[gi];
    end
  endgenerate

  // Single driver for the packed count, decade by decade
  always_comb begin
    for (int i = 0; i < BCS_DIGITS; i++) begin
      count_q[4*i+:4] = digit[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wrap pulse timing
  bcs_wrap_state_t wst_q;
  logic [BCS_TMR_W-1:0] tmr_q;
  logic wrap_ev;
  logic hi_at_reset_q;

  // Remember whether the count stood at 6000 or above; frozen while reset clears it
  always_ff @(posedge clk) begin
    if (rst_n) begin
      hi_at_reset_q <= (count_q[15:12] >= BCS_RST_WRAP_DIGIT);
    end
  end

  logic rst_wrap_q;
  always_ff @(posedge clk) begin
    rst_wrap_q <= pin_rst_q[2] && !pin_rst_q[1] && hi_at_reset_q;
  end

  assign wrap_ev = chain[BCS_DIGITS] || rst_wrap_q;

  always_ff @(posedge clk) begin
    if (wrap_ev) begin
      wst_q <= BCS_W_DELAY;
      tmr_q <= BCS_TMR_W'(BCS_WRAP_DELAY_CYC - 1);
    end else begin
      case (wst_q)
        BCS_W_DELAY: begin
          if (tmr_q == '0) begin
            wst_q <= BCS_W_PULSE;
            tmr_q <= BCS_TMR_W'(BCS_WRAP_WIDTH_CYC - 1);
          end else begin
            tmr_q <= tmr_q - 1'b1;
          end
        end
        BCS_W_PULSE: begin
          if (tmr_q == '0) begin
            wst_q <= BCS_W_IDLE;
          end else begin
            tmr_q <= tmr_q - 1'b1;
          end
        end
        BCS_W_IDLE: begin
          tmr_q <= '0;
        end
        default: begin
          wst_q <= BCS_W_IDLE;
          tmr_q <= '0;
        end
      endcase
    end
  end

  logic wrap_q;
  always_ff @(posedge clk) begin
    wrap_q <= (wst_q == BCS_W_PULSE) && !wrap_ev;
  end
  assign wrap_pulse = wrap_q;

  ////////////////////////////////////////////////////////////////////////////
  // Status flags
  logic match_q;
  logic null_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      match_q <= 1'b1;
      null_q <= 1'b0;
    end else begin
      match_q <= !(count_q == cmp_q);
      null_q <= !(count_q == BCS_COUNT_ZERO);
    end
  end
  assign match_b = match_q;
  assign null_b = null_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Cycles since the latest wrap event, saturating; retriggers restart it
  logic [7:0] ev_age_q;
  always_ff @(posedge clk) begin
    if (wrap_ev) begin
      ev_age_q <= 8'h00;
    end else if (!rst_n || ev_age_q == 8'hff) begin
      ev_age_q <= 8'hff;
    end else begin
      ev_age_q <= ev_age_q + 8'h01;
    end
  end

  property p_up_wrap;
    @(posedge clk) disable iff (!rst_n)
    (count_rise && dir_sync_q[1] && count_q == BCS_COUNT_MAX) |=> (count_q == BCS_COUNT_ZERO);
  endproperty
  a_up_wrap: assert property (p_up_wrap) else $error("up wrap missed");

  property p_dn_wrap;
    @(posedge clk) disable iff (!rst_n)
    (count_rise && !dir_sync_q[1] && count_q == BCS_COUNT_ZERO) |=> (count_q == BCS_COUNT_MAX);
  endproperty
  a_dn_wrap: assert property (p_dn_wrap) else $error("down wrap missed");

  property p_wrap_delay;
    @(posedge clk) disable iff (!rst_n)
    $rose(wrap_pulse) == (ev_age_q == 8'(BCS_WRAP_DELAY_CYC + 1));
  endproperty
  a_wrap_delay: assert property (p_wrap_delay) else $error("wrap pulse late");

  property p_wrap_width;
    @(posedge clk) disable iff (!rst_n || wrap_ev)
    $rose(wrap_pulse) |-> wrap_pulse [*8] ##1 wrap_pulse ##1 wrap_pulse ##1 !wrap_pulse;
  endproperty
  a_wrap_width: assert property (p_wrap_width) else $error("wrap width wrong");

  property p_match;
    @(posedge clk) disable iff (!rst_n)
    rst_n |=> (match_b == ($past(count_q) != $past(cmp_q)));
  endproperty
  a_match: assert property (p_match) else $error("match flag wrong");

  property p_null;
    @(posedge clk) disable iff (!rst_n)
    (count_q == BCS_COUNT_ZERO) |=> !null_b;
  endproperty
  a_null: assert property (p_null) else $error("null flag wrong");

  property p_inhibit;
    @(posedge clk) disable iff (!rst_n)
    inhibit |=> $stable(count_q);
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("count moved in preset");

  property p_step;
    @(posedge clk) disable iff (!rst_n)
    (count_rise && dir_sync_q[1] && count_q[3:0] != BCS_DIGIT_MAX)
      |=> (count_q[3:0] == $past(count_q[3:0]) + 4'h1);
  endproperty
  a_step: assert property (p_step) else $error("up step wrong");

  property p_digits;
    @(posedge clk) disable iff (!rst_n)
    (count_q[3:0] <= BCS_DIGIT_MAX) && (count_q[15:12] <= BCS_DIGIT_MAX);
  endproperty
  a_digits: assert property (p_digits) else $error("digit out of range");
endmodule

//--- hdl/bcs_decade.sv
// One BCD decade with borrow and carry chaining
module bcs_decade (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic step,
  input wire logic up,
  input wire logic clear,
  output logic [3:0] digit_q,
  output logic roll
);
  import bcs_pkg::*;
  logic [3:0] digit_d;
  always_comb begin
    roll = step && (up ? (digit_q == BCS_DIGIT_MAX) : (digit_q == BCS_DIGIT_ZERO));
    digit_d = digit_q;
    if (step) begin
      if (up) begin
        digit_d = (digit_q == BCS_DIGIT_MAX) ? BCS_DIGIT_ZERO : digit_q + 4'h1;
      end else begin
        digit_d = (digit_q == BCS_DIGIT_ZERO) ? BCS_DIGIT_MAX : digit_q - 4'h1;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      digit_q <= BCS_DIGIT_ZERO;
    end else if (clear) begin
      digit_q <= BCS_DIGIT_ZERO;
    end else begin
      digit_q <= digit_d;
    end
  end
endmodule

//--- shared/bcs_pkg.sv
// Constants and types for the BCD counter status-output block
package bcs_pkg;
  localparam int unsigned BCS_DIGITS = 4;
  localparam logic [3:0] BCS_DIGIT_MAX = 4'h9;
  localparam logic [3:0] BCS_DIGIT_ZERO = 4'h0;
  localparam logic [15:0] BCS_COUNT_MAX = 16'h9999;
  localparam logic [15:0] BCS_COUNT_ZERO = 16'h0000;
  localparam logic [3:0] BCS_RST_WRAP_DIGIT = 4'h6;
  localparam int unsigned BCS_CLK_MHZ = 100;
  localparam int unsigned BCS_WRAP_DELAY_NS = 500;
  localparam int unsigned BCS_WRAP_WIDTH_NS = 100;
  localparam int unsigned BCS_WRAP_DELAY_CYC = (BCS_WRAP_DELAY_NS * BCS_CLK_MHZ) / 1000;
  localparam int unsigned BCS_WRAP_WIDTH_CYC = (BCS_WRAP_WIDTH_NS * BCS_CLK_MHZ) / 1000;
  localparam int unsigned BCS_TMR_W = 8;
  typedef logic [15:0] bcs_count_t;
  typedef enum logic [1:0] {BCS_W_IDLE, BCS_W_DELAY, BCS_W_PULSE} bcs_wrap_state_t;
endpackage

//--- verification/bcs_far_side.sv
// Count source, direction switch and cascaded counter model
module bcs_far_side (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic counter_preset_ctl,
  input wire logic wrap_pulse,
  output logic count_in,
  output logic up_dn,
  output int wrap_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wrap_d1;
  initial begin
    count_in = 1'b0;
    up_dn = 1'b1;
    wrap_cnt = 0;
    wrap_d1 = 1'b0;
  end
  // Direction settles first; both pulse levels held five cycles
  task automatic pulse(input logic dir);
    @(negedge clk) up_dn = dir;
    repeat (3) @(negedge clk);
    count_in = 1'b1;
    repeat (5) @(negedge clk);
    count_in = 1'b0;
    repeat (5) @(negedge clk);
  endtask
  // Cascaded stage counts wrap rises, ignoring them in reset or preset
  always @(posedge clk) begin
    if (rst_b && !counter_preset_ctl && wrap_pulse && !wrap_d1) wrap_cnt <= wrap_cnt + 1;
    wrap_d1 <= wrap_pulse;
  end
endmodule

//--- verification/testbench.sv
// Self-checking bench for the BCD counter status block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import bcs_pkg::*;
  logic clk, rst_b, counter_preset_ctl, count_in, up_dn, wrap_pulse, match_b, null_b;
  logic match_cc_b;
  logic [15:0] compare_raw;
  logic [31:0] seed;
  bcs_count_t count_q, exp;
  int wrap_cnt, w, mismatches = 0, checked = 0;

  bcs_counter_status #(.COMMON_CATHODE(1'b0)) u_dut (.clk(clk), .rst_b(rst_b),
    .count_in(count_in), .up_dn(up_dn), .counter_preset_ctl(counter_preset_ctl),
    .compare_raw(compare_raw), .wrap_pulse(wrap_pulse), .match_b(match_b),
    .null_b(null_b), .count_q(count_q));
  // Common-cathode copy sees the inverted compare levels and must match alike
  bcs_counter_status #(.COMMON_CATHODE(1'b1)) u_dut_cc (.clk(clk), .rst_b(rst_b),
    .count_in(count_in), .up_dn(up_dn), .counter_preset_ctl(counter_preset_ctl),
    .compare_raw(~compare_raw), .wrap_pulse(), .match_b(match_cc_b),
    .null_b(), .count_q());
  bcs_far_side u_src (.clk(clk), .rst_b(rst_b), .counter_preset_ctl(counter_preset_ctl),
    .wrap_pulse(wrap_pulse), .count_in(count_in), .up_dn(up_dn), .wrap_cnt(wrap_cnt));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Next BCD count, carries rippling decade by decade
  function automatic bcs_count_t nxt(input bcs_count_t c, input logic u);
    logic [3:0] d;
    for (int i = 0; i < 4; i++) begin
      d = c[4*i+:4];
      c[4*i+:4] = u ? (d == 4'h9 ? 4'h0 : d + 4'h1) : (d == 4'h0 ? 4'h9 : d - 4'h1);
      if (d != (u ? 4'h9 : 4'h0)) break;
    end
    return c;
  endfunction
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] want);
    checked++;
    if (seen !== want) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, want, seen);
    end
  endtask
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic step(input logic dir);
    u_src.pulse(dir);
    exp = nxt(exp, dir);
    check("count", count_q, exp);
    check("null", 16'(null_b), 16'(exp != 16'h0000));
    check("match", 16'(match_b), 16'(exp != compare_raw));
    check("match cc", 16'(match_cc_b), 16'(exp != compare_raw));
  endtask
  task automatic wrap_step(input logic dir);
    w = wrap_cnt;
    step(dir);
    check("wrap early", 16'(wrap_pulse), 16'h0000);
    repeat (60) @(negedge clk);
    check("wrap", 16'(wrap_cnt), 16'(w + 1));
  endtask
  task automatic do_reset(input int n);
    w = wrap_cnt;
    @(negedge clk) rst_b = 1'b0;
    #1 check("async clear", count_q, 16'h0000);
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    exp = 16'h0000;
    repeat (80) @(negedge clk);
    check("reset wrap", 16'(wrap_cnt), 16'(w + n));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    counter_preset_ctl = 1'b0;
    compare_raw = 16'h9999;
    exp = 16'h0000;
    seed = 32'd81652;
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    repeat (6) @(negedge clk);
    check("null", 16'(null_b), 16'h0000);
    wrap_step(1'b0);
    wrap_step(1'b1);
    wrap_step(1'b0);
    $display("test wrap done");
    do_reset(1);
    step(1'b1);
    do_reset(0);
    $display("test reset done");
    counter_preset_ctl = 1'b1;
    repeat (4) @(negedge clk);
    u_src.pulse(1'b1);
    check("preset hold", count_q, exp);
    counter_preset_ctl = 1'b0;
    repeat (4) @(negedge clk);
    $display("test preset done");
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      compare_raw = seed[1] ? nxt(exp, seed[0]) : seed[31:16];
      step(seed[0]);
    end
    $display("test random done");
    finish_test();
  end
  initial begin
    #100us;
    mismatches++;
    finish_test();
  end
endmodule
